// *** common/ssr_pkg.sv ***
// constants for the setup register bank: frame layout, offsets, defaults, timing
package ssr_pkg;
  localparam logic [1:0] SSR_CMD_WRITE = 2'h1;
  localparam logic [4:0] SSR_ADDR_REG = 5'h05;
  localparam logic [4:0] SSR_ADDR_WD = 5'h06;
  localparam logic [4:0] SSR_FRAME_BITS = 5'h10;
  localparam logic [4:0] SSR_CMD_BYTE_LAST = 5'h07;
  localparam logic [4:0] SSR_DATA_FIRST = 5'h08;
  localparam int SSR_CMD_HI = 15;
  localparam int SSR_CMD_LO = 14;
  localparam int SSR_BYTE_CMD_HI = 7;
  localparam int SSR_BYTE_CMD_LO = 6;
  localparam int SSR_BYTE_ADDR_HI = 5;
  localparam int SSR_BYTE_ADDR_LO = 1;
  localparam logic [7:0] SSR_REG_RESET = 8'h80;
  localparam logic [7:0] SSR_WD_RESET = 8'h42;
  localparam int SSR_SYNC_BIT = 7;
  localparam int SSR_UV_HI = 6;
  localparam int SSR_UV_LO = 5;
  localparam int SSR_RSTD_HI = 4;
  localparam int SSR_RSTD_LO = 3;
  localparam int SSR_AUX_BIT = 2;
  localparam int SSR_CYC_HI = 1;
  localparam int SSR_CYC_LO = 0;
  localparam int SSR_WD_DEADLINE_BIT = 7;
  localparam logic [1:0] SSR_UV_IRQ_CODE = 2'h1;
  localparam logic [1:0] SSR_UV_LOW_CODE = 2'h2;
  localparam int SSR_CLK_MHZ = 10;
  localparam int SSR_RST_T0_US = 1000;
  localparam int SSR_RST_T1_US = 5000;
  localparam int SSR_RST_T2_US = 10000;
  localparam int SSR_RST_T3_US = 20000;
  localparam int SSR_CYC_T0_US = 200;
  localparam int SSR_CYC_T1_US = 400;
  localparam int SSR_CYC_T2_US = 800;
  localparam int SSR_CYC_T3_US = 1600;
  localparam int SSR_RST_C0 = SSR_RST_T0_US * SSR_CLK_MHZ;
  localparam int SSR_RST_C1 = SSR_RST_T1_US * SSR_CLK_MHZ;
  localparam int SSR_RST_C2 = SSR_RST_T2_US * SSR_CLK_MHZ;
  localparam int SSR_RST_C3 = SSR_RST_T3_US * SSR_CLK_MHZ;
  localparam int SSR_CYC_C0 = SSR_CYC_T0_US * SSR_CLK_MHZ;
  localparam int SSR_CYC_C1 = SSR_CYC_T1_US * SSR_CLK_MHZ;
  localparam int SSR_CYC_C2 = SSR_CYC_T2_US * SSR_CLK_MHZ;
  localparam int SSR_CYC_C3 = SSR_CYC_T3_US * SSR_CLK_MHZ;
endpackage : ssr_pkg

// *** hdl/ssr_setup_regs.sv ***
// setup register bank behind the serial port, with reset hold and cyclic timing
// Behaviour
// - setup registers are written only while the device is in initialization mode.
// - sync bit 0 samples wake input anytime; 1 only during first I/O activation.
// - threshold 00/11 reset 0.9, 01 interrupt 0.9 reset 0.7, 10 reset 0.7.
// - reset held low 1, 5, 10 or 20 ms after supply recovers.
// - auxiliary select bit gives 3.3 V when 0, 5.0 V when 1.
// - first I/O activation time 200, 400, 800 or 1600 us by code.
// - watchdog setup register at 0_0110 holds eight fields b7 to b0.
// - deadline enable cleared imposes no interrupt-to-read timing constraint.
`timescale 1ns/1ns
`default_nettype none
module ssr_setup_regs
  import ssr_pkg::*;
#(
  parameter logic [17:0] RST_HOLD_0 = 18'(SSR_RST_C0),
  parameter logic [17:0] RST_HOLD_1 = 18'(SSR_RST_C1),
  parameter logic [17:0] RST_HOLD_2 = 18'(SSR_RST_C2),
  parameter logic [17:0] RST_HOLD_3 = 18'(SSR_RST_C3),
  parameter logic [14:0] CYC_ON_0 = 15'(SSR_CYC_C0),
  parameter logic [14:0] CYC_ON_1 = 15'(SSR_CYC_C1),
  parameter logic [14:0] CYC_ON_2 = 15'(SSR_CYC_C2),
  parameter logic [14:0] CYC_ON_3 = 15'(SSR_CYC_C3)
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic init_mode,
  input wire logic supply_ok,
  input wire logic cyclic_start,
  output logic [7:0] regulator_setup,
  output logic [7:0] watchdog_setup,
  output logic io_sense_sync,
  output logic [1:0] supply_uv_threshold_sel,
  output logic [1:0] reset_pulse_length_sel,
  output logic aux_voltage_sel,
  output logic [1:0] cyclic_on_time_sel,
  output logic irq_read_deadline_en,
  output logic uv_irq_en,
  output logic uv_reset_low_thr,
  output logic reset_out_n,
  output logic io0_active,
  output logic io1_sample_en
);

  typedef struct packed {
    logic cs_s1, cs_s2, cs_s3;
    logic sck_s1, sck_s2, sck_s3;
    logic mosi_s1, mosi_s2;
    logic sup_s1, sup_s2, sup_s3;
    logic [15:0] shift;
    logic [4:0] bcnt;
    logic [7:0] rd;
    logic miso;
    logic [7:0] reg_q;
    logic [7:0] wd_q;
    logic uv_irq;
    logic uv_low;
    logic [17:0] hold_cnt;
    logic rst_n;
    logic [14:0] cyc_cnt;
    logic io0;
    logic io1;
  } ssr_state_type;

  ssr_state_type st_q, st_d;
  logic [7:0] cmd_byte;
  logic commit;

  always_comb begin
    st_d = st_q;
    // pins cross into clk_sys through two flops; third stage only for edges
    st_d.cs_s1 = spi_cs_n;
    st_d.cs_s2 = st_q.cs_s1;
    st_d.cs_s3 = st_q.cs_s2;
    st_d.sck_s1 = spi_sclk;
    st_d.sck_s2 = st_q.sck_s1;
    st_d.sck_s3 = st_q.sck_s2;
    st_d.mosi_s1 = spi_mosi;
    st_d.mosi_s2 = st_q.mosi_s1;
    st_d.sup_s1 = supply_ok;
    st_d.sup_s2 = st_q.sup_s1;
    st_d.sup_s3 = st_q.sup_s2;
    cmd_byte = {st_q.shift[6:0], st_q.mosi_s2};
    commit = 1'b0;
    if (st_q.cs_s2) begin
      st_d.bcnt = '0;
      st_d.miso = 1'b0;
      // frame ends at chip-select release; only full 16-bit writes commit
      if (!st_q.cs_s3 && st_q.bcnt == SSR_FRAME_BITS
          && st_q.shift[SSR_CMD_HI:SSR_CMD_LO] == SSR_CMD_WRITE) begin
        commit = init_mode;
        // parity position not checked; host keeps it zero
        if (commit && st_q.shift[SSR_CMD_HI-2:SSR_CMD_LO-5] == SSR_ADDR_REG) begin
          st_d.reg_q = st_q.shift[7:0];
        end
        if (commit && st_q.shift[SSR_CMD_HI-2:SSR_CMD_LO-5] == SSR_ADDR_WD) begin
          st_d.wd_q = st_q.shift[7:0];
        end
      end
    end else begin
      if (st_q.sck_s2 && !st_q.sck_s3 && st_q.bcnt != SSR_FRAME_BITS) begin
        st_d.shift = {st_q.shift[14:0], st_q.mosi_s2};
        st_d.bcnt = st_q.bcnt + 5'h01;
        if (st_q.bcnt == SSR_CMD_BYTE_LAST) begin
          unique case (cmd_byte[SSR_BYTE_ADDR_HI:SSR_BYTE_ADDR_LO])
            SSR_ADDR_REG: st_d.rd = st_q.reg_q;
            SSR_ADDR_WD: st_d.rd = st_q.wd_q;
            default: st_d.rd = '0;
          endcase
        end
      end
      if (!st_q.sck_s2 && st_q.sck_s3 && st_q.bcnt >= SSR_DATA_FIRST) begin
        st_d.miso = st_q.rd[7];
        st_d.rd = {st_q.rd[6:0], 1'b0};
      end
    end
    // undervoltage behaviour decode; 00 and 11 both mean reset at the high level
    st_d.uv_irq = st_q.reg_q[SSR_UV_HI:SSR_UV_LO] == SSR_UV_IRQ_CODE;
    st_d.uv_low = st_q.reg_q[SSR_UV_HI:SSR_UV_LO] == SSR_UV_IRQ_CODE
                  || st_q.reg_q[SSR_UV_HI:SSR_UV_LO] == SSR_UV_LOW_CODE;
    // reset hold: length taken at supply recovery so a later write cannot cut it
    if (!st_q.sup_s2) begin
      st_d.rst_n = 1'b0;
      st_d.hold_cnt = '0;
    end else if (!st_q.sup_s3) begin
      st_d.rst_n = 1'b0;
      unique case (st_q.reg_q[SSR_RSTD_HI:SSR_RSTD_LO])
        2'h0: st_d.hold_cnt = RST_HOLD_0;
        2'h1: st_d.hold_cnt = RST_HOLD_1;
        2'h2: st_d.hold_cnt = RST_HOLD_2;
        2'h3: st_d.hold_cnt = RST_HOLD_3;
      endcase
    end else if (st_q.hold_cnt > 18'h00001) begin
      st_d.hold_cnt = st_q.hold_cnt - 18'h00001;
    end else if (st_q.hold_cnt == 18'h00001) begin
      st_d.hold_cnt = '0;
      st_d.rst_n = 1'b1;
    end
    // first I/O activation window for cyclic sensing
    if (cyclic_start && !st_q.io0) begin
      st_d.io0 = 1'b1;
      unique case (st_q.reg_q[SSR_CYC_HI:SSR_CYC_LO])
        2'h0: st_d.cyc_cnt = CYC_ON_0;
        2'h1: st_d.cyc_cnt = CYC_ON_1;
        2'h2: st_d.cyc_cnt = CYC_ON_2;
        2'h3: st_d.cyc_cnt = CYC_ON_3;
      endcase
    end else if (st_q.cyc_cnt > 15'h0001) begin
      st_d.cyc_cnt = st_q.cyc_cnt - 15'h0001;
    end else if (st_q.cyc_cnt == 15'h0001) begin
      st_d.cyc_cnt = '0;
      st_d.io0 = 1'b0;
    end
    st_d.io1 = !st_q.reg_q[SSR_SYNC_BIT] || st_d.io0;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.cs_s1 <= 1'b1;
      st_q.cs_s2 <= 1'b1;
      st_q.cs_s3 <= 1'b1;
      st_q.reg_q <= SSR_REG_RESET;
      st_q.wd_q <= SSR_WD_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign spi_miso = st_q.miso;
  assign regulator_setup = st_q.reg_q;
  assign watchdog_setup = st_q.wd_q;
  assign io_sense_sync = st_q.reg_q[SSR_SYNC_BIT];
  assign supply_uv_threshold_sel = st_q.reg_q[SSR_UV_HI:SSR_UV_LO];
  assign reset_pulse_length_sel = st_q.reg_q[SSR_RSTD_HI:SSR_RSTD_LO];
  assign aux_voltage_sel = st_q.reg_q[SSR_AUX_BIT];
  assign cyclic_on_time_sel = st_q.reg_q[SSR_CYC_HI:SSR_CYC_LO];
  // when clear, no deadline is enforced downstream
  assign irq_read_deadline_en = st_q.wd_q[SSR_WD_DEADLINE_BIT];
  assign uv_irq_en = st_q.uv_irq;
  assign uv_reset_low_thr = st_q.uv_low;
  assign reset_out_n = st_q.rst_n;
  assign io0_active = st_q.io0;
  assign io1_sample_en = st_q.io1;

  write_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !init_mode |=> $stable(st_q.reg_q) && $stable(st_q.wd_q))
    else $error("setup register changed outside init mode");
  wd_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    commit && st_q.shift[SSR_CMD_HI-2:SSR_CMD_LO-5] == SSR_ADDR_WD
    |=> st_q.wd_q == $past(st_q.shift[7:0]))
    else $error("watchdog setup write not stored");
  hold_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_q.cs_s2 && !st_q.cs_s3 && !init_mode |=> $stable(st_q.reg_q))
    else $error("frame outside init mode altered register");
  uv_decode_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 uv_irq_en == ($past(supply_uv_threshold_sel) == 2'h1)
    && uv_reset_low_thr == ($past(supply_uv_threshold_sel) inside {2'h1, 2'h2}))
    else $error("undervoltage decode wrong");
  reset_release_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(reset_out_n) |-> $past(st_q.hold_cnt) == 18'h00001 && $past(st_q.sup_s2, 2))
    else $error("reset released without full hold");
  reset_load_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_q.sup_s2 && !st_q.sup_s3 && reset_pulse_length_sel == 2'h0
    |=> st_q.hold_cnt == RST_HOLD_0 && !reset_out_n)
    else $error("reset hold length not loaded");
  cyc_load_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cyclic_start && !io0_active && cyclic_on_time_sel == 2'h1
    |=> io0_active && st_q.cyc_cnt == CYC_ON_1)
    else $error("activation time not loaded");
  io1_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    io_sense_sync && !io0_active |-> !io1_sample_en || $past(!io_sense_sync))
    else $error("second input sampled outside activation");
  por_default_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(resetn) |-> regulator_setup == SSR_REG_RESET && watchdog_setup == SSR_WD_RESET)
    else $error("defaults not restored by reset");

endmodule : ssr_setup_regs
`default_nettype wire

// *** test/ssr_host_model.sv ***
// host serial master model: 16-bit frames, mode 0, msb first
`timescale 1ns/1ns
`default_nettype none
module ssr_host_model (
  input wire logic clk_sys,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // 6 clk per phase: margin over the 3 clk the synchronisers need
  task automatic frame(input logic [15:0] f, output logic [7:0] rd);
    @(negedge clk_sys) spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = f[i];
      repeat (6) @(negedge clk_sys);
      if (i < 8) rd[i] = spi_miso;
      spi_sclk = 1'b1;
      repeat (6) @(negedge clk_sys);
      spi_sclk = 1'b0;
    end
    repeat (6) @(negedge clk_sys);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // released line shows no stale bit
    repeat (8) @(negedge clk_sys);
  endtask : frame
  function automatic logic [15:0] cmd(input logic [1:0] c, input logic [4:0] a,
                                      input logic [7:0] d);
    return {c, a, 1'b0, d};
  endfunction : cmd
endmodule : ssr_host_model
`default_nettype wire

// *** test/ssr_setup_regs_tb_top.sv ***
// self-checking bench for the setup register bank
`timescale 1ns/1ns
`default_nettype none
module ssr_setup_regs_tb_top;
  import ssr_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic init_mode = 1'b1;
  logic supply_ok = 1'b0;
  logic cyclic_start = 1'b0;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, io_sense_sync, aux_voltage_sel;
  logic irq_read_deadline_en, uv_irq_en, uv_reset_low_thr, reset_out_n;
  logic io0_active, io1_sample_en;
  logic [1:0] supply_uv_threshold_sel, reset_pulse_length_sel, cyclic_on_time_sel;
  logic [7:0] regulator_setup, watchdog_setup, rd, d;
  int fails = 0;
  int n_checks = 0;
  int n, m, cyc_exp;
  always #50 clk_sys = ~clk_sys;
  ssr_host_model i_ssr_host_model (.clk_sys(clk_sys), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  // short hold counts keep the run brief; activation windows keep their real length
  localparam int HOLD_STEP = 20;
  ssr_setup_regs #(.RST_HOLD_0(18'(HOLD_STEP)), .RST_HOLD_1(18'(2 * HOLD_STEP)),
    .RST_HOLD_2(18'(3 * HOLD_STEP)), .RST_HOLD_3(18'(4 * HOLD_STEP)))
    i_ssr_setup_regs (.clk_sys(clk_sys), .resetn(resetn),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .init_mode(init_mode), .supply_ok(supply_ok), .cyclic_start(cyclic_start),
    .regulator_setup(regulator_setup), .watchdog_setup(watchdog_setup),
    .io_sense_sync(io_sense_sync), .supply_uv_threshold_sel(supply_uv_threshold_sel),
    .reset_pulse_length_sel(reset_pulse_length_sel), .aux_voltage_sel(aux_voltage_sel),
    .cyclic_on_time_sel(cyclic_on_time_sel), .irq_read_deadline_en(irq_read_deadline_en),
    .uv_irq_en(uv_irq_en), .uv_reset_low_thr(uv_reset_low_thr), .reset_out_n(reset_out_n),
    .io0_active(io0_active), .io1_sample_en(io1_sample_en));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(input logic [1:0] c, input logic [4:0] a, input logic [7:0] v);
    i_ssr_host_model.frame(i_ssr_host_model.cmd(c, a, v), rd);
  endtask : xfer
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic do_reset;
    resetn = 1'b0;
    repeat (3) @(negedge clk_sys);
    resetn = 1'b1;
    @(negedge clk_sys);
    chk("reg default", SSR_REG_RESET, regulator_setup);
    chk("wd default", SSR_WD_RESET, watchdog_setup);
    chk("io1 sample", 1'b0, io1_sample_en);
  endtask : do_reset
  initial begin
    #6000000;
    fails++;
    tally_and_finish();
  end
  initial begin
    do_reset();
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      d = {c[1], c[1:0], c[1:0], c[0], c[1:0]};
      xfer(SSR_CMD_WRITE, SSR_ADDR_REG, d);
      chk("fields", d, {io_sense_sync, supply_uv_threshold_sel, reset_pulse_length_sel,
        aux_voltage_sel, cyclic_on_time_sel});
      chk("uv irq", c == 1, uv_irq_en);
      chk("uv low", c == 1 || c == 2, uv_reset_low_thr);
      xfer(2'h0, SSR_ADDR_REG, 8'h00);
      chk("readback", d, rd);
      supply_ok = 1'b0;
      repeat (6) @(negedge clk_sys);
      chk("rst low", 1'b0, reset_out_n);
      supply_ok = 1'b1;
      n = 0;
      while (reset_out_n !== 1'b1 && n < 200) begin
        @(negedge clk_sys);
        n++;
      end
      chk("hold span", 1, n >= HOLD_STEP * (c + 1) + 2 && n <= HOLD_STEP * (c + 1) + 4);
      cyc_exp = c == 0 ? SSR_CYC_C0 : c == 1 ? SSR_CYC_C1 : c == 2 ? SSR_CYC_C2
                : SSR_CYC_C3;
      cyclic_start = 1'b1;
      @(negedge clk_sys);
      cyclic_start = 1'b0;
      n = 0;
      m = 0;
      // window opens at the edge that took the start, so look before waiting
      repeat (cyc_exp + 10) begin
        if (io0_active === 1'b1) n++;
        if (io1_sample_en !== (io0_active | ~d[7])) m++;
        @(negedge clk_sys);
      end
      chk("on span", cyc_exp, n);
      chk("io1 follow", 0, m);
    end
    $display("test codes done");
    init_mode = 1'b0;
    xfer(SSR_CMD_WRITE, SSR_ADDR_REG, 8'h55);
    chk("locked", d, regulator_setup);
    init_mode = 1'b1;
    xfer(2'h3, SSR_ADDR_REG, 8'h55);
    chk("bad cmd", d, regulator_setup);
    xfer(SSR_CMD_WRITE, 5'h07, 8'h55);
    xfer(2'h0, 5'h07, 8'hFF);
    chk("unmapped", 8'h00, rd);
    $display("test protect done");
    xfer(SSR_CMD_WRITE, SSR_ADDR_WD, 8'h81);
    chk("wd reg", 8'h81, watchdog_setup);
    chk("deadline", 1'b1, irq_read_deadline_en);
    xfer(SSR_CMD_WRITE, SSR_ADDR_WD, 8'h3E);
    chk("wd reg", 8'h3E, watchdog_setup);
    chk("deadline", 1'b0, irq_read_deadline_en);
    $display("test watchdog done");
    do_reset();
    $display("test rereset done");
    tally_and_finish();
  end
endmodule : ssr_setup_regs_tb_top
`default_nettype wire
